// [mrc_pkg.sv]
/*
  Shared constants and types for the receive control and status block
  of the Ethernet MAC: register offsets, masks, frame limits, receive states.
  Assumes a single 32-bit register port and an MII or 7-wire PHY link.
*/
package mrc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [15:0] MRC_CTRL_ADDR = 16'ha010;
  localparam logic [15:0] MRC_STAT_ADDR = 16'ha014;
  localparam logic [31:0] MRC_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MRC_STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] MRC_CTRL_WMASK = 32'h0000_6f7f;
  localparam logic [31:0] MRC_STAT_W1C_MASK = 32'h0000_efe0;
  localparam logic [31:0] MRC_IRQ_EN_MASK = 32'h0000_6f00;
  localparam logic [31:0] MRC_FRAME_CLR_MASK = 32'h0000_4fe0;

  //////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int MRC_B_RECEIVE_ON = 0;
  localparam int MRC_B_HALT_REQUEST = 1;
  localparam int MRC_B_ACCEPT_OVERSIZE = 2;
  localparam int MRC_B_ACCEPT_UNDERSIZE = 3;
  localparam int MRC_B_STRIP_CHECKSUM = 4;
  localparam int MRC_B_PASS_CONTROL_FRAMES = 5;
  localparam int MRC_B_SKIP_CHECKSUM = 6;
  localparam int MRC_B_PARITY_IRQ_ENABLE = 13;

  // status field positions
  localparam int MRC_B_CONTROL_FRAME_SEEN = 5;
  localparam int MRC_B_RECEIVE_IRQ_FLAG = 6;
  localparam int MRC_B_SEVEN_WIRE_SOURCE = 7;
  localparam int MRC_B_MISALIGN_FLAG = 8;
  localparam int MRC_B_CHECKSUM_FLAG = 9;
  localparam int MRC_B_OVERFLOW_FLAG = 10;
  localparam int MRC_B_OVERSIZE_FLAG = 11;
  localparam int MRC_B_FIFO_PARITY_FLAG = 13;
  localparam int MRC_B_GOOD_FRAME_FLAG = 14;
  localparam int MRC_B_RECEPTION_STOPPED = 15;

  //////////////////////////////////////////////////////////////////////////
  // frame constants
  localparam logic [15:0] MRC_MAX_LEN = 16'd1518;
  localparam logic [15:0] MRC_MIN_LEN = 16'd64;
  localparam logic [15:0] MRC_CTL_TYPE = 16'h8808;
  localparam logic [15:0] MRC_TYPE_HI_IDX = 16'd12;
  localparam logic [15:0] MRC_TYPE_LO_IDX = 16'd13;
  localparam logic [15:0] MRC_STRIP_BYTES = 16'd4;
  localparam logic [7:0] MRC_SFD = 8'hd5;
  localparam logic [31:0] MRC_CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] MRC_CRC_POLY = 32'hedb8_8320;
  localparam logic [31:0] MRC_CRC_RESIDUE = 32'hdebb_20e3;
  localparam logic [2:0] MRC_STEP_MII = 3'h4;
  localparam logic [2:0] MRC_STEP_SEVEN = 3'h1;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    MRC_IDLE = 2'b00,
    MRC_HUNT = 2'b01,
    MRC_DATA = 2'b10,
    MRC_DROP = 2'b11
  } mrc_state_t;

  typedef struct packed {
    logic rxDv;
    logic rxEr;
    logic [3:0] rxd;
  } mrc_mii_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mrc_reg_req_t;

  typedef struct packed {
    logic done;
    logic accept;
    logic sevenWire;
    logic [15:0] length;
  } mrc_frame_t;

endpackage

// [mrc_receive_control.sv]
/*
  Receive control and status logic of the Ethernet MAC: control and
  status registers, frame reception from an MII or 7-wire PHY, checksum,
  length checks, byte stream towards the receive FIFO.
  Assumes the PHY link arrives asynchronously with its own receive clock,
  the FIFO, address filter and MAC control sit on clk.
*/
module mrc_receive_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire mrc_pkg::mrc_reg_req_t regReq,
  output logic [31:0] regRdata,
  // phy link
  input wire logic linkClk,
  input wire mrc_pkg::mrc_mii_t miiPins,
  input wire logic sevenWireSel,
  // mac control and address filter
  input wire logic immediateHalt,
  input wire logic addressMatch,
  // receive fifo
  output logic [7:0] outData,
  output logic outValid,
  input wire logic fifoFull,
  input wire logic fifoParityErr,
  // frame result and interrupt
  output mrc_pkg::mrc_frame_t frameInfo,
  output logic irqPulse
);
  import mrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] ctrl;
  logic [31:0] stat;
  logic [31:0] next_stat;
  logic [31:0] evSet;
  logic [31:0] irqHits;
  logic [31:0] w1cBits;
  logic lkS1;
  logic lkS2;
  logic lkS3;
  mrc_mii_t pinS1;
  mrc_mii_t pinS2;
  logic sample;
  logic dvNow;
  mrc_state_t state;
  logic receiveOn;
  logic haltRequest;
  logic acceptOversize;
  logic acceptUndersize;
  logic stripChecksum;
  logic passControl;
  logic skipChecksum;
  logic stopNow;
  logic stopPrev;
  logic stopRise;
  logic startOk;
  logic [2:0] step;
  logic [7:0] shifted;
  logic [7:0] acc;
  logic [2:0] bitCnt;
  logic [3:0] bitSum;
  logic sfdHit;
  logic byteDone;
  logic frameEnd;
  logic [15:0] byteCount;
  logic [31:0] crc;
  logic [15:0] typeReg;
  logic frameRxErr;
  logic frameOvf;
  logic pushNow;
  logic pushLost;
  logic [7:0] dly [4];
  logic lenLong;
  logic lenShort;
  logic crcBad;
  logic misalign;
  logic checksumErr;
  logic oversizeErr;
  logic undersizeRej;
  logic isCtl;
  logic good;
  logic accept;

  ////////////////////////////////////////////////////////////////////////////
  // checksum step, one byte, reflected
  function automatic logic [31:0] crcNext(input logic [31:0] c,
                                          input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ MRC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control fields
  assign receiveOn = ctrl[MRC_B_RECEIVE_ON];
  assign haltRequest = ctrl[MRC_B_HALT_REQUEST];
  assign acceptOversize = ctrl[MRC_B_ACCEPT_OVERSIZE];
  assign acceptUndersize = ctrl[MRC_B_ACCEPT_UNDERSIZE];
  assign stripChecksum = ctrl[MRC_B_STRIP_CHECKSUM];
  assign passControl = ctrl[MRC_B_PASS_CONTROL_FRAMES];
  assign skipChecksum = ctrl[MRC_B_SKIP_CHECKSUM];

  ////////////////////////////////////////////////////////////////////////////
  // link synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      lkS1 <= 1'b0;
      lkS2 <= 1'b0;
      lkS3 <= 1'b0;
      pinS1 <= '0;
      pinS2 <= '0;
    end else begin
      lkS1 <= linkClk;
      lkS2 <= lkS1;
      lkS3 <= lkS2;
      pinS1 <= miiPins;
      pinS2 <= pinS1;
    end
  end

  // sample mid-period, on the falling link edge
  assign sample = lkS3 & ~lkS2;
  assign dvNow = pinS2.rxDv;

  ////////////////////////////////////////////////////////////////////////////
  // bit and nibble assembly
  assign step = sevenWireSel ? MRC_STEP_SEVEN : MRC_STEP_MII;
  assign shifted = sevenWireSel ? {pinS2.rxd[0], acc[7:1]}
                                : {pinS2.rxd, acc[7:4]};
  assign bitSum = {1'b0, bitCnt} + {1'b0, step};

  assign stopNow = ~receiveOn | immediateHalt;
  assign startOk = receiveOn & ~haltRequest & ~immediateHalt;
  assign stopRise = stopNow & ~stopPrev;

  assign sfdHit = (state == MRC_HUNT) & ~stopNow & sample & dvNow
                  & (shifted == MRC_SFD);
  assign byteDone = (state == MRC_DATA) & ~stopNow & sample & dvNow
                    & bitSum[3];
  assign frameEnd = (state == MRC_DATA) & ~stopNow & sample & ~dvNow;

  ////////////////////////////////////////////////////////////////////////////
  // receive state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= MRC_IDLE;
    end else begin
      unique case (state)
        MRC_IDLE: begin
          if (sample && dvNow) begin
            state <= startOk ? MRC_HUNT : MRC_DROP;
          end
        end
        MRC_HUNT: begin
          if (stopNow) begin
            state <= MRC_DROP;
          end else if (sample && !dvNow) begin
            state <= MRC_IDLE;
          end else if (sfdHit) begin
            state <= MRC_DATA;
          end
        end
        MRC_DATA: begin
          if (stopNow) begin
            state <= MRC_DROP;
          end else if (frameEnd) begin
            state <= MRC_IDLE;
          end
        end
        MRC_DROP: begin
          if (sample && !dvNow) begin
            state <= MRC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stopPrev <= 1'b1;
    end else begin
      stopPrev <= stopNow;
    end
  end

  // shift register and bit counter
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= 8'h00;
      bitCnt <= 3'h0;
    end else begin
      if (sample && dvNow
          && (state == MRC_HUNT || state == MRC_DATA)) begin
        acc <= shifted;
      end
      if (sfdHit) begin
        bitCnt <= 3'h0;
      end else if ((state == MRC_DATA) && sample && dvNow) begin
        bitCnt <= bitSum[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-frame tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      byteCount <= 16'h0000;
      crc <= MRC_CRC_INIT;
      typeReg <= 16'h0000;
    end else if (sfdHit) begin
      byteCount <= 16'h0000;
      crc <= MRC_CRC_INIT;
      typeReg <= 16'h0000;
    end else if (byteDone) begin
      if (byteCount != 16'hffff) begin
        byteCount <= byteCount + 16'h0001;
      end
      crc <= crcNext(crc, shifted);
      if (byteCount == MRC_TYPE_HI_IDX) begin
        typeReg[15:8] <= shifted;
      end
      if (byteCount == MRC_TYPE_LO_IDX) begin
        typeReg[7:0] <= shifted;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frameRxErr <= 1'b0;
    end else if (sfdHit) begin
      frameRxErr <= 1'b0;
    end else if ((state == MRC_DATA) && sample && dvNow && pinS2.rxEr) begin
      frameRxErr <= 1'b1;
    end
  end

  assign pushNow = byteDone
                   & (~stripChecksum | (byteCount >= MRC_STRIP_BYTES));
  assign pushLost = pushNow & fifoFull;

  always_ff @(posedge clk) begin
    if (rst) begin
      frameOvf <= 1'b0;
    end else if (sfdHit) begin
      frameOvf <= 1'b0;
    end else if (pushLost) begin
      frameOvf <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte output, four-byte delay for stripping
  always_ff @(posedge clk) begin
    if (rst) begin
      dly[0] <= 8'h00;
    end else if (byteDone) begin
      dly[0] <= shifted;
    end
  end

  for (genvar gi = 1; gi < 4; gi++) begin : g_dly
    always_ff @(posedge clk) begin
      if (rst) begin
        dly[gi] <= 8'h00;
      end else if (byteDone) begin
        dly[gi] <= dly[gi-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outData <= 8'h00;
      outValid <= 1'b0;
    end else begin
      outValid <= pushNow & ~fifoFull;
      if (pushNow) begin
        outData <= stripChecksum ? dly[3] : shifted;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // end-of-frame evaluation
  assign lenLong = byteCount > MRC_MAX_LEN;
  assign lenShort = byteCount < MRC_MIN_LEN;
  assign crcBad = ~skipChecksum & (crc != MRC_CRC_RESIDUE);
  assign misalign = (bitCnt != 3'h0) & crcBad;
  assign checksumErr = crcBad | frameRxErr;
  assign oversizeErr = lenLong & ~acceptOversize;
  assign undersizeRej = lenShort & ~acceptUndersize;
  assign isCtl = (typeReg == MRC_CTL_TYPE) & addressMatch
                 & (byteCount == MRC_MIN_LEN);
  assign good = ~checksumErr & ~misalign & ~frameOvf & ~oversizeErr
                & ~undersizeRej;
  assign accept = good & (~isCtl | passControl);

  always_comb begin
    evSet = 32'h0000_0000;
    if (frameEnd) begin
      evSet[MRC_B_CONTROL_FRAME_SEEN] = isCtl;
      evSet[MRC_B_SEVEN_WIRE_SOURCE] = sevenWireSel;
      evSet[MRC_B_MISALIGN_FLAG] = misalign;
      evSet[MRC_B_CHECKSUM_FLAG] = checksumErr;
      evSet[MRC_B_OVERSIZE_FLAG] = oversizeErr;
      evSet[MRC_B_GOOD_FRAME_FLAG] = good;
    end
    evSet[MRC_B_OVERFLOW_FLAG] = pushLost;
    evSet[MRC_B_FIFO_PARITY_FLAG] = fifoParityErr;
    evSet[MRC_B_RECEPTION_STOPPED] = stopRise;
  end

  assign irqHits = evSet & ctrl & MRC_IRQ_EN_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // status register
  assign w1cBits = (regReq.wr && (regReq.addr == MRC_STAT_ADDR))
                   ? (regReq.wdata & MRC_STAT_W1C_MASK) : 32'h0000_0000;

  always_comb begin
    next_stat = stat & ~w1cBits;
    if (sfdHit) begin
      next_stat = next_stat & ~MRC_FRAME_CLR_MASK;
    end
    next_stat = next_stat | evSet;
    if (irqHits != 32'h0000_0000) begin
      next_stat[MRC_B_RECEIVE_IRQ_FLAG] = 1'b1;
    end
    next_stat = next_stat & MRC_STAT_W1C_MASK;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat <= MRC_STAT_RESET;
    end else begin
      stat <= next_stat;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqPulse <= 1'b0;
    end else begin
      irqPulse <= irqHits != 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= MRC_CTRL_RESET;
    end else begin
      if (regReq.wr && (regReq.addr == MRC_CTRL_ADDR)) begin
        ctrl <= regReq.wdata & MRC_CTRL_WMASK;
      end
      if (fifoParityErr && ctrl[MRC_B_PARITY_IRQ_ENABLE]) begin
        ctrl[MRC_B_RECEIVE_ON] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port and frame result
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else if (regReq.rd && (regReq.addr == MRC_CTRL_ADDR)) begin
      regRdata <= ctrl;
    end else if (regReq.rd && (regReq.addr == MRC_STAT_ADDR)) begin
      regRdata <= stat;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frameInfo <= '0;
    end else begin
      frameInfo.done <= frameEnd;
      if (frameEnd) begin
        frameInfo.accept <= accept;
        frameInfo.sevenWire <= sevenWireSel;
        frameInfo.length <= byteCount;
      end
    end
  end

endmodule

// [mrc_receive_control_props.sv]
/*
  Assertion checker for the receive control block, bound to its ports.
  Assumes one clock domain and the register map of the package.
*/
module mrc_receive_control_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire mrc_pkg::mrc_reg_req_t regReq,
  input wire logic [31:0] regRdata,
  // phy link
  input wire logic linkClk,
  input wire mrc_pkg::mrc_mii_t miiPins,
  input wire logic sevenWireSel,
  // mac control and filter
  input wire logic immediateHalt,
  input wire logic addressMatch,
  // fifo and result
  input wire logic [7:0] outData,
  input wire logic outValid,
  input wire logic fifoFull,
  input wire logic fifoParityErr,
  input wire mrc_pkg::mrc_frame_t frameInfo,
  input wire logic irqPulse
);
  timeunit 1ns;
  timeprecision 100ps;
  import mrc_pkg::*;
  logic [31:0] ctrl;
  ////////////////////////////////////////
  // shadow of the control register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= 32'h0;
    end else begin
      if (regReq.wr && regReq.addr == MRC_CTRL_ADDR) begin
        ctrl <= regReq.wdata & MRC_CTRL_WMASK;
      end
      if (fifoParityErr && ctrl[MRC_B_PARITY_IRQ_ENABLE]) begin
        ctrl[MRC_B_RECEIVE_ON] <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence ctrl_rd_s;
    regReq.rd && regReq.addr == MRC_CTRL_ADDR;
  endsequence
  sequence stat_rd_s;
    regReq.rd && regReq.addr == MRC_STAT_ADDR;
  endsequence
  sequence good_end_s;
    frameInfo.done && frameInfo.accept;
  endsequence
  ////////////////////////////////////////
  ctrl_readback_a: assert property (
    ctrl_rd_s |=> regRdata == $past(ctrl))
    else $error("control read wrong");
  stat_reserved_a: assert property (
    stat_rd_s |=> (regRdata & ~MRC_STAT_W1C_MASK) == 32'h0)
    else $error("status reserved bits set");
  unmapped_zero_a: assert property (
    regReq.rd && regReq.addr != MRC_CTRL_ADDR
      && regReq.addr != MRC_STAT_ADDR |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  good_irq_a: assert property (
    good_end_s and $past(ctrl[MRC_B_GOOD_FRAME_FLAG]) |-> irqPulse)
    else $error("good frame without interrupt");
  irq_cause_a: assert property (
    irqPulse |-> frameInfo.done || $past(fifoParityErr) || $past(fifoFull))
    else $error("interrupt without event");
  irq_enabled_a: assert property (
    irqPulse |-> ($past(ctrl) & MRC_IRQ_EN_MASK) != 32'h0)
    else $error("interrupt with no enable");
  off_silent_a: assert property (
    !ctrl[MRC_B_RECEIVE_ON] [*3] |=> !outValid)
    else $error("byte out while off");
  full_drop_a: assert property (
    outValid |-> !$past(fifoFull))
    else $error("byte pushed into full fifo");
  source_bit_a: assert property (
    frameInfo.done |-> frameInfo.sevenWire == $past(sevenWireSel))
    else $error("frame source wrong");
  long_reject_a: assert property (
    frameInfo.done && frameInfo.length > MRC_MAX_LEN
      && !$past(ctrl[MRC_B_ACCEPT_OVERSIZE]) |-> !frameInfo.accept)
    else $error("long frame accepted");
  short_reject_a: assert property (
    frameInfo.done && frameInfo.length < MRC_MIN_LEN
      && !$past(ctrl[MRC_B_ACCEPT_UNDERSIZE]) |-> !frameInfo.accept)
    else $error("short frame accepted");
endmodule

bind mrc_receive_control mrc_receive_control_props chk (
  .clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
  .linkClk(linkClk), .miiPins(miiPins), .sevenWireSel(sevenWireSel),
  .immediateHalt(immediateHalt), .addressMatch(addressMatch),
  .outData(outData), .outValid(outValid), .fifoFull(fifoFull),
  .fifoParityErr(fifoParityErr), .frameInfo(frameInfo),
  .irqPulse(irqPulse)
);

// [mrc_phy_model.sv]
/*
  Behavioural phy: sends one frame on the link, MII or 7-wire.
  Assumes the receiver samples pins on the link clock's falling edge.
*/
module mrc_phy_model (
  // link clock and pins
  output logic linkClk,
  output mrc_pkg::mrc_mii_t miiPins
);
  timeunit 1ns;
  timeprecision 100ps;
  import mrc_pkg::*;
  initial begin
    linkClk = 1'b0;
    miiPins = '0;
  end
  // one link period, pins change on the rising edge
  task automatic tick(input logic dv, input logic er, input logic [3:0] d);
    linkClk = 1'b1;
    miiPins = '{rxDv: dv, rxEr: er, rxd: d};
    #16;
    linkClk = 1'b0;
    #16;
  endtask
  task automatic send(input logic [7:0] f[$], input logic sev,
      input int extra, input logic er);
    logic [7:0] p[$];
    p = {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hd5};
    p = {p, f};
    foreach (p[i]) begin
      if (sev) begin
        for (int b = 0; b < 8; b++) begin
          tick(1'b1, 1'b0, {3'h0, p[i][b]});
        end
      end else begin
        tick(1'b1, er && i == 20, p[i][3:0]);
        tick(1'b1, 1'b0, p[i][7:4]);
      end
    end
    for (int b = 0; b < extra; b++) begin
      tick(1'b1, 1'b0, {3'h0, b[0]});
    end
    // released lines toggle, clock then stands still
    for (int b = 0; b < 2; b++) begin
      tick(1'b0, 1'b0, ~miiPins.rxd);
    end
  endtask
endmodule

// [mrc_receive_control_bench.sv]
/*
  Self-checking bench: register access, frame trials, aborts, parity.
  Assumes the checker file binds itself and the phy model is compiled.
*/
module mrc_receive_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mrc_pkg::*;
  localparam logic [15:0] ipType = 16'h0800;
  logic clk = 1'b0;
  logic rst = 1'b1;
  mrc_reg_req_t regReq = '0;
  logic [31:0] regRdata;
  logic linkClk;
  mrc_mii_t miiPins;
  logic sevenWireSel = 1'b0;
  logic immediateHalt = 1'b0;
  logic addressMatch = 1'b1;
  logic [7:0] outData;
  logic outValid;
  logic fifoFull = 1'b0;
  logic fifoParityErr = 1'b0;
  mrc_frame_t frameInfo;
  logic irqPulse;
  int fails = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int byteCount = 0;
  logic doneSeen = 1'b0;
  logic irqSeen = 1'b0;
  logic [7:0] frm[$];
  mrc_receive_control dut (
    .clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .linkClk(linkClk), .miiPins(miiPins), .sevenWireSel(sevenWireSel),
    .immediateHalt(immediateHalt), .addressMatch(addressMatch),
    .outData(outData), .outValid(outValid), .fifoFull(fifoFull),
    .fifoParityErr(fifoParityErr), .frameInfo(frameInfo),
    .irqPulse(irqPulse)
  );
  mrc_phy_model phy (.linkClk(linkClk), .miiPins(miiPins));
  always #2 clk = ~clk;
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // monitor and timeout
  always @(posedge clk) begin
    cycles++;
    if (outValid === 1'b1) begin
      check({24'h0, outData}, {24'h0, frm[byteCount]});
      byteCount++;
    end
    if (frameInfo.done === 1'b1) doneSeen = 1'b1;
    if (irqPulse === 1'b1) irqSeen = 1'b1;
    if (cycles == 95000) begin
      fails++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    check(regRdata, exp);
  endtask
  // frame bytes with checksum, optionally corrupted
  task automatic build(input int len, input logic [15:0] typ,
      input logic bad);
    logic [31:0] c;
    frm.delete();
    for (int i = 0; i < len - 4; i++) frm.push_back(8'(i * 7));
    frm[12] = typ[15:8];
    frm[13] = typ[7:0];
    c = 32'hffff_ffff;
    foreach (frm[i]) begin
      c ^= {24'h0, frm[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ MRC_CRC_POLY : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) frm.push_back(c[8*i +: 8]);
  endtask
  // flg: 0 seven-wire, 1 bad checksum, 2 rx error, 3 fifo full
  task automatic trial(input logic [31:0] ctl, input int len,
      input logic [15:0] typ, input logic [3:0] flg,
      input logic [31:0] stat, input logic acc, input int bytes);
    wr(MRC_CTRL_ADDR, ctl);
    build(len, typ, flg[1]);
    sevenWireSel <= flg[0];
    fifoFull <= flg[3];
    byteCount = 0;
    doneSeen = 1'b0;
    irqSeen = 1'b0;
    phy.send(frm, flg[0], flg[0] ? 3 : 0, flg[2]);
    repeat (8) @(posedge clk);
    fifoFull <= 1'b0;
    check(doneSeen, 1'b1);
    check(irqSeen, stat[6]);
    check(frameInfo.accept, acc);
    check(frameInfo.sevenWire, flg[0]);
    check(frameInfo.length, len);
    check(byteCount, bytes);
    rd(MRC_STAT_ADDR, stat);
  endtask
  task automatic midway(input logic [31:0] ctl, input logic imm,
      input logic done, input logic [31:0] stat);
    wr(MRC_CTRL_ADDR, 32'h1);
    wr(MRC_STAT_ADDR, 32'hffff_ffff);
    build(64, ipType, 1'b0);
    doneSeen = 1'b0;
    byteCount = 0;
    fork
      phy.send(frm, 1'b0, 0, 1'b0);
      begin
        repeat (200) @(posedge clk);
        immediateHalt <= imm;
        wr(MRC_CTRL_ADDR, ctl);
      end
    join
    repeat (8) @(posedge clk);
    immediateHalt <= 1'b0;
    check(doneSeen, done);
    rd(MRC_STAT_ADDR, stat);
  endtask
  task automatic parity();
    @(posedge clk);
    fifoParityErr <= 1'b1;
    @(posedge clk);
    fifoParityErr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(MRC_CTRL_ADDR, 32'h0);
    rd(MRC_STAT_ADDR, 32'h0);
    wr(MRC_CTRL_ADDR, 32'hffff_ffff);
    wr(16'ha018, 32'hffff_ffff);
    rd(MRC_CTRL_ADDR, 32'h6f7f);
    rd(16'ha018, 32'h0);
    trial(32'h4001, 64, ipType, 4'h0, 32'h4040, 1'b1, 64);
    trial(32'h0011, 64, ipType, 4'h0, 32'h4000, 1'b1, 60);
    trial(32'h6f01, 64, ipType, 4'h2, 32'h0240, 1'b0, 64);
    trial(32'h0041, 64, ipType, 4'h2, 32'h4000, 1'b1, 64);
    trial(32'h0001, 64, ipType, 4'h4, 32'h0200, 1'b0, 64);
    trial(32'h0001, 40, ipType, 4'h0, 32'h0000, 1'b0, 40);
    trial(32'h0009, 40, ipType, 4'h0, 32'h4000, 1'b1, 40);
    trial(32'h0001, 1519, ipType, 4'h0, 32'h0800, 1'b0, 1519);
    trial(32'h0005, 1519, ipType, 4'h0, 32'h4000, 1'b1, 1519);
    trial(32'h0001, 64, MRC_CTL_TYPE, 4'h0, 32'h4020, 1'b0, 64);
    trial(32'h0021, 64, MRC_CTL_TYPE, 4'h0, 32'h4020, 1'b1, 64);
    @(posedge clk) addressMatch <= 1'b0;
    trial(32'h0001, 64, MRC_CTL_TYPE, 4'h0, 32'h4000, 1'b1, 64);
    @(posedge clk) addressMatch <= 1'b1;
    trial(32'h0001, 64, ipType, 4'h3, 32'h0380, 1'b0, 64);
    trial(32'h0401, 64, ipType, 4'h8, 32'h0440, 1'b0, 0);
    midway(32'h0, 1'b0, 1'b0, 32'h8000);
    midway(32'h1, 1'b1, 1'b0, 32'h8000);
    midway(32'h3, 1'b0, 1'b1, 32'h4000);
    #1;
    doneSeen = 1'b0;
    phy.send(frm, 1'b0, 0, 1'b0);
    repeat (8) @(posedge clk);
    check(doneSeen, 1'b0);
    wr(MRC_STAT_ADDR, 32'hffff_ffff);
    wr(MRC_CTRL_ADDR, 32'h2001);
    parity();
    rd(MRC_CTRL_ADDR, 32'h2000);
    rd(MRC_STAT_ADDR, 32'ha040);
    wr(MRC_STAT_ADDR, 32'h0);
    rd(MRC_STAT_ADDR, 32'ha040);
    wr(MRC_STAT_ADDR, 32'hffff_ffff);
    rd(MRC_STAT_ADDR, 32'h0);
    wr(MRC_CTRL_ADDR, 32'h0001);
    parity();
    rd(MRC_CTRL_ADDR, 32'h0001);
    rd(MRC_STAT_ADDR, 32'h2000);
    complete_run();
  end
endmodule
